// ==== rtl/range_guard_defs.vh ====
/*
 Constants for the management memory range guard: register offsets,
 field positions, decode codes, segment sizes and fixed windows.
 Assumes inclusion by bare name from the guard module.
*/
`ifndef RANGE_GUARD_DEFS_VH
`define RANGE_GUARD_DEFS_VH

// Register byte offsets
`define OFF_RANGE_CTRL 12'h000
`define OFF_ROW_POP0 12'h004
`define OFF_ROW_POP1 12'h008
`define OFF_IRQ_STATUS 12'h00c
`define OFF_IRQ_ENABLE 12'h010
`define OFF_IRQ_CLEAR 12'h014
`define OFF_TOP_OF_MEM 12'h018

// Range control fields
`define VIOL_BIT 0
`define LOCK_BIT 1
`define LOW_LSB 2
`define LOW_MSB 3
`define UP_LSB 4
`define UP_MSB 5
`define GMS_LSB 6
`define GMS_MSB 7

// Two-bit select codes
`define SEL_00 2'b00
`define SEL_01 2'b01
`define SEL_10 2'b10
`define SEL_11 2'b11

// Segment sizes and fixed windows
`define TOP_SIZE_512K 32'h0008_0000
`define TOP_SIZE_1M 32'h0010_0000
`define HIGH_BASE 32'hfeea_0000
`define HIGH_LAST 32'hfeeb_ffff
`define AB_BASE 32'h000a_0000
`define AB_LAST 32'h000b_ffff
`define TOM_RESET 32'h0800_0000

// Routing codes
`define ROUTE_MEM 2'b00
`define ROUTE_GFX 2'b01
`define ROUTE_HUB 2'b10

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== rtl/smm_memory_range_guard.v ====
/*
 Management memory range decode, lock and violation logic.
 Assumes a synchronous host request strobe with its attributes valid in
 the same cycle, and an AXI4-Lite master that holds valid until ready.
*/
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
//Contract
// - Upper select 11 enables top segment at 1 MB, high segment conditional.
// - Upper 00 disables both; 01 high only; 10 top at 512 KB plus high.
// - Top segment sits below top of memory; high segment at FEEA0000 window.
// - Non-management accesses to extended segments go to the hub interface.
// - Lock makes upper select read-only.
// - High segment enabled only when lower select is 00.
// - Lower 00 blocks AB writes; 01 makes AB plain writable RAM.
// - Lower 10: only management code reads reach memory in AB.
// - Lower 11: all management operations to AB reach memory.
// - Under lock, lower bit 3 read-only; bit 2 writable only if bit 3 set.
// - Lock freezes lock bit, graphics select, upper select, lower MSB.
// - Lock set by ordinary write, cleared only by reset.
// - Lock freezes both row population registers.
// - Out-of-mode top or high segment access sets violation, not write-backs.
// - Violation sticks until software writes one to clear it.
`timescale 1ns/1ps
`include "range_guard_defs.vh"

module smm_memory_range_guard #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // AXI4-Lite write address and data
    input wire [ADDR_W-1:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // Host request
    input wire host_req_in,
    input wire [31:0] host_addr_in,
    input wire host_write_in,
    input wire host_mgmt_mode_in,
    input wire host_code_in,
    input wire host_writeback_in,
    // Routing answer
    output reg route_valid_out,
    output reg [1:0] route_target_out,
    output reg route_write_block_out,
    // Lock state and interrupt
    output wire space_lock_out,
    output wire irq_out
);

    reg [1:0] upper_range_select_reg;
    reg [1:0] lower_range_select_reg;
    reg [1:0] graphics_memory_select_reg;
    reg space_lock_reg;
    reg extended_range_violation_reg;
    reg irq_enable_reg;
    reg [31:0] row_population_reg;
    reg [31:0] row_population_reg_second;
    reg [31:0] top_of_mem_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg aw_have_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_have_reg;

    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
    wire wr_ctrl = do_write && (aw_addr_reg == `OFF_RANGE_CTRL) && w_strb_reg[0];
    wire wr_clr = do_write && (aw_addr_reg == `OFF_IRQ_CLEAR) && w_strb_reg[0];
    wire wr_row0 = do_write && (aw_addr_reg == `OFF_ROW_POP0);
    wire wr_row1 = do_write && (aw_addr_reg == `OFF_ROW_POP1);
    wire wr_en = do_write && (aw_addr_reg == `OFF_IRQ_ENABLE) && w_strb_reg[0];
    wire wr_tom = do_write && (aw_addr_reg == `OFF_TOP_OF_MEM);
    wire wr_known = (aw_addr_reg == `OFF_RANGE_CTRL) || (aw_addr_reg == `OFF_ROW_POP0) ||
        (aw_addr_reg == `OFF_ROW_POP1) || (aw_addr_reg == `OFF_IRQ_STATUS) ||
        (aw_addr_reg == `OFF_IRQ_ENABLE) || (aw_addr_reg == `OFF_IRQ_CLEAR) ||
        (aw_addr_reg == `OFF_TOP_OF_MEM);

    assign s_axi_awready_out = !aw_have_reg;
    assign s_axi_wready_out = !w_have_reg;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign space_lock_out = space_lock_reg;
    assign irq_out = extended_range_violation_reg && irq_enable_reg;

    // Byte-lane merge
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Segment decode
    reg top_en;
    reg high_en;
    reg [31:0] top_size;
    always @* begin
        top_en = 1'b0;
        high_en = 1'b0;
        top_size = `TOP_SIZE_512K;
        case (upper_range_select_reg)
            `SEL_00: begin
                top_en = 1'b0;
                high_en = 1'b0;
            end
            `SEL_01: begin
                high_en = 1'b1;
            end
            `SEL_10: begin
                top_en = 1'b1;
                high_en = 1'b1;
                top_size = `TOP_SIZE_512K;
            end
            `SEL_11: begin
                top_en = 1'b1;
                high_en = 1'b1;
                top_size = `TOP_SIZE_1M;
            end
            default: begin
                top_en = 1'b0;
            end
        endcase
        if (lower_range_select_reg != `SEL_00) begin
            high_en = 1'b0;
        end
    end

    wire in_top = top_en && (host_addr_in >= (top_of_mem_reg - top_size)) &&
        (host_addr_in < top_of_mem_reg);
    wire in_high_win = (host_addr_in >= `HIGH_BASE) && (host_addr_in <= `HIGH_LAST);
    wire in_high = high_en && in_high_win;
    wire in_ab = (host_addr_in >= `AB_BASE) && (host_addr_in <= `AB_LAST);
    wire gfx_on = (graphics_memory_select_reg != `SEL_00);
    wire [1:0] legacy_target = gfx_on ? `ROUTE_GFX : `ROUTE_HUB;

    reg [1:0] target;
    reg block;
    always @* begin
        target = `ROUTE_MEM;
        block = 1'b0;
        if (in_top || in_high) begin
            target = host_mgmt_mode_in ? `ROUTE_MEM : `ROUTE_HUB;
        end else if (in_high_win) begin
            // closed high window never reaches memory
            target = `ROUTE_HUB;
        end else if (in_ab) begin
            case (lower_range_select_reg)
                `SEL_00: begin
                    target = legacy_target;
                    block = host_write_in;
                end
                `SEL_01: begin
                    target = `ROUTE_MEM;
                end
                `SEL_10: begin
                    target = (host_mgmt_mode_in && host_code_in && !host_write_in) ?
                        `ROUTE_MEM : legacy_target;
                end
                `SEL_11: begin
                    target = host_mgmt_mode_in ? `ROUTE_MEM : legacy_target;
                end
                default: begin
                    target = legacy_target;
                end
            endcase
        end
    end

    wire viol_event = host_req_in && (in_top || in_high) && !host_mgmt_mode_in &&
        !host_writeback_in;

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            route_valid_out <= 1'b0;
            route_target_out <= `ROUTE_MEM;
            route_write_block_out <= 1'b0;
        end else begin
            route_valid_out <= host_req_in;
            if (host_req_in) begin
                route_target_out <= target;
                route_write_block_out <= block;
            end
        end
    end

    // Register file and write channel
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            upper_range_select_reg <= `SEL_00;
            lower_range_select_reg <= `SEL_00;
            graphics_memory_select_reg <= `SEL_00;
            space_lock_reg <= 1'b0;
            extended_range_violation_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            row_population_reg <= 32'h0000_0000;
            row_population_reg_second <= 32'h0000_0000;
            top_of_mem_reg <= `TOM_RESET;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && !aw_have_reg) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_have_reg) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            if (wr_ctrl) begin
                if (!space_lock_reg) begin
                    graphics_memory_select_reg <= w_data_reg[`GMS_MSB:`GMS_LSB];
                    lower_range_select_reg[1] <= w_data_reg[`LOW_MSB];
                    lower_range_select_reg[0] <= w_data_reg[`LOW_LSB];
                    upper_range_select_reg <= w_data_reg[`UP_MSB:`UP_LSB];
                    space_lock_reg <= w_data_reg[`LOCK_BIT];
                end else if (lower_range_select_reg[1]) begin
                    // bit 2 needs bit 3 set
                    lower_range_select_reg[0] <= w_data_reg[`LOW_LSB];
                end
            end
            if (wr_row0 && !space_lock_reg) begin
                row_population_reg <= merge(row_population_reg, w_data_reg, w_strb_reg);
            end
            if (wr_row1 && !space_lock_reg) begin
                row_population_reg_second <=
                    merge(row_population_reg_second, w_data_reg, w_strb_reg);
            end
            if (wr_tom && !space_lock_reg) begin
                top_of_mem_reg <= merge(top_of_mem_reg, w_data_reg, w_strb_reg);
            end
            if (wr_en) begin
                irq_enable_reg <= w_data_reg[`VIOL_BIT];
            end
            if (viol_event) begin
                extended_range_violation_reg <= 1'b1;
            end else if ((wr_clr || wr_ctrl) && w_data_reg[`VIOL_BIT]) begin
                extended_range_violation_reg <= 1'b0;
            end
        end
    end

    // Read channel
    reg [31:0] rd_word;
    reg rd_known;
    always @* begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        case (s_axi_araddr_in)
            `OFF_RANGE_CTRL: begin
                rd_word[`GMS_MSB:`GMS_LSB] = graphics_memory_select_reg;
                rd_word[`UP_MSB:`UP_LSB] = upper_range_select_reg;
                rd_word[`LOW_MSB:`LOW_LSB] = lower_range_select_reg;
                rd_word[`LOCK_BIT] = space_lock_reg;
                rd_word[`VIOL_BIT] = extended_range_violation_reg;
            end
            `OFF_ROW_POP0: rd_word = row_population_reg;
            `OFF_ROW_POP1: rd_word = row_population_reg_second;
            `OFF_IRQ_STATUS: rd_word[`VIOL_BIT] = extended_range_violation_reg;
            `OFF_IRQ_ENABLE: rd_word[`VIOL_BIT] = irq_enable_reg;
            `OFF_IRQ_CLEAR: rd_word = 32'h0000_0000;
            `OFF_TOP_OF_MEM: rd_word = top_of_mem_reg;
            default: rd_known = 1'b0;
        endcase
    end

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `RESP_OKAY;
        end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

endmodule

// ==== verification/range_guard_chk.sv ====
/* Checker for routing, lock and interrupt behaviour of the range guard.
   Assumes binding to smm_memory_range_guard, seeing its ports only. */
`timescale 1ns/1ps
module range_guard_chk (
    // Clock and reset
    input wire core_clk_in,
    input wire reset_n_in,
    // Host request
    input wire host_req_in,
    input wire [31:0] host_addr_in,
    input wire host_write_in,
    input wire host_mgmt_mode_in,
    input wire host_writeback_in,
    // Watched outputs
    input wire route_valid_out,
    input wire [1:0] route_target_out,
    input wire route_write_block_out,
    input wire space_lock_out,
    input wire irq_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_user_high;
        host_req_in && !host_mgmt_mode_in && host_addr_in[31:17] == 15'h7f75;
    endsequence
    sequence s_user_event;
        host_req_in && !host_mgmt_mode_in && !host_writeback_in;
    endsequence
    a_route_answer: assert property (host_req_in |=> route_valid_out)
        else $error("route answer missing");
    a_route_single: assert property (!host_req_in |=> !route_valid_out)
        else $error("route valid without request");
    a_lock_sticky: assert property (space_lock_out |=> space_lock_out)
        else $error("lock bit dropped");
    a_user_high_off: assert property (s_user_high |=> route_target_out != 2'h0)
        else $error("user access to high segment reached memory");
    a_block_cause: assert property (route_valid_out && route_write_block_out |->
        $past(host_write_in) && $past(host_addr_in[31:17]) == 15'h0005)
        else $error("write block without segment write");
    a_irq_cause: assert property ($rose(irq_out) |-> $past(host_req_in && !host_mgmt_mode_in
        && !host_writeback_in) || s_axi_bvalid_out)
        else $error("interrupt rose without cause");
    a_irq_release: assert property ($fell(irq_out) |-> s_axi_bvalid_out)
        else $error("interrupt fell without a write");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    c_user_event: cover property (s_user_event ##1 route_valid_out);
endmodule

bind smm_memory_range_guard range_guard_chk range_guard_chk_i (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .host_req_in(host_req_in),
    .host_addr_in(host_addr_in),
    .host_write_in(host_write_in),
    .host_mgmt_mode_in(host_mgmt_mode_in),
    .host_writeback_in(host_writeback_in),
    .route_valid_out(route_valid_out),
    .route_target_out(route_target_out),
    .route_write_block_out(route_write_block_out),
    .space_lock_out(space_lock_out),
    .irq_out(irq_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in)
);

// ==== verification/host_bus_model.sv ====
/* Processor host bus model issuing one-cycle requests.
   Assumes the guard samples request and attributes on one rising edge. */
`timescale 1ns/1ps
module host_bus_model (
    // Clock
    input wire core_clk_in,
    // Host request
    output reg host_req_out,
    output reg [31:0] host_addr_out,
    output reg [3:0] host_attr_out
);
    initial begin
        host_req_out = 1'h0;
        host_addr_out = 32'h0;
        host_attr_out = 4'h0;
    end
    // Attribute order: write, management, code, write-back
    task issue(input [31:0] a, input [3:0] attr);
        begin
            @(posedge core_clk_in);
            host_req_out <= 1'h1;
            host_addr_out <= a;
            host_attr_out <= attr;
            @(posedge core_clk_in);
            host_req_out <= 1'h0;
            host_addr_out <= ~a;
            host_attr_out <= ~attr;
        end
    endtask
endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench for the range guard: register bus, decode, lock.
   Assumes the host model drives the host side and AXI is driven here. */
`timescale 1ns/1ps
module testbench;
    reg core_clk_in = 1'h0;
    reg reset_n_in = 1'h0;
    reg [11:0] awaddr = 12'h0;
    reg [11:0] araddr = 12'h0;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, h_req, rv, blk, lock, irq;
    wire [1:0] bresp, rresp, tgt;
    wire [31:0] rdata, h_addr;
    wire [3:0] h_attr;
    integer mismatches = 0, n_checks = 0, cycles = 0, i;
    reg [31:0] rd;
    reg [1:0] resp;
    reg [8:0] e;
    // Entries: graphics, lower select, mgmt, code, write, target, block
    localparam [62:0] TAB = {9'h102, 9'h0c4, 9'h0e8, 9'h0a4, 9'h0b0, 9'h048, 9'h00d};
    smm_memory_range_guard smm_memory_range_guard_i (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .host_req_in(h_req), .host_addr_in(h_addr), .host_write_in(h_attr[3]),
        .host_mgmt_mode_in(h_attr[2]), .host_code_in(h_attr[1]),
        .host_writeback_in(h_attr[0]), .route_valid_out(rv), .route_target_out(tgt),
        .route_write_block_out(blk), .space_lock_out(lock), .irq_out(irq));
    host_bus_model host_bus_model_i (.core_clk_in(core_clk_in), .host_req_out(h_req),
        .host_addr_out(h_addr), .host_attr_out(h_attr));
    initial forever #20 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task axi_wr(input [11:0] a, input [31:0] d);
        reg ta, tw, tb;
        begin
            @(posedge core_clk_in);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            do begin
                @(negedge core_clk_in);
                ta = awready;
                tw = wready;
                tb = bvalid;
                resp = bresp;
                @(posedge core_clk_in);
                if (ta) awvalid <= 1'h0;
                if (tw) wvalid <= 1'h0;
            end while (!tb);
            bready <= 1'h0;
        end
    endtask
    task rchk(input [11:0] a, input [31:0] exp);
        reg ta, tr;
        begin
            @(posedge core_clk_in);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            do begin
                @(negedge core_clk_in);
                ta = arready;
                tr = rvalid;
                rd = rdata;
                resp = rresp;
                @(posedge core_clk_in);
                if (ta) arvalid <= 1'h0;
            end while (!tr);
            rready <= 1'h0;
            chk(rd, exp);
        end
    endtask
    task hchk(input [31:0] a, input [3:0] attr, input [2:0] exp);
        begin
            host_bus_model_i.issue(a, attr);
            #1;
            chk({28'h0, rv, tgt, blk}, {28'h0, 1'h1, exp});
        end
    endtask
    task vchk(input ex);
        begin
            rchk(12'h00c, {31'h0, ex});
            axi_wr(12'h014, 32'h1);
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        reset_n_in <= 1'h1;
        rchk(12'h000, 32'h0);
        rchk(12'h018, 32'h08000000);
        rchk(12'h020, 32'h0);
        chk({30'h0, resp}, 32'h2);
        axi_wr(12'h020, 32'h1);
        chk({30'h0, resp}, 32'h2);
        for (i = 0; i < 4; i = i + 1) begin
            axi_wr(12'h000, i << 4);
            hchk(32'h07f80000, 4'h0, (i > 1) ? 3'h4 : 3'h0);
            vchk(i > 1);
            hchk(32'h07f00000, 4'h0, (i == 3) ? 3'h4 : 3'h0);
            vchk(i == 3);
            hchk(32'hfeebfffc, 4'h0, 3'h4);
            vchk(i != 0);
        end
        hchk(32'h07f80000, 4'h1, 3'h4);
        vchk(1'h0);
        hchk(32'hfeea0000, 4'h4, 3'h0);
        vchk(1'h0);
        axi_wr(12'h000, 32'h34);
        hchk(32'hfeea0000, 4'h0, 3'h4);
        vchk(1'h0);
        for (i = 0; i < 7; i = i + 1) begin
            e = TAB[i*9 +: 9];
            axi_wr(12'h000, {24'h0, e[8], 3'h0, e[7:6], 2'h0});
            hchk(32'h000a0000, {e[3], e[5], e[4], 1'h0}, e[2:0]);
        end
        axi_wr(12'h000, 32'h30);
        axi_wr(12'h010, 32'h1);
        hchk(32'h07ffff00, 4'h0, 3'h4);
        chk({31'h0, irq}, 32'h1);
        axi_wr(12'h010, 32'h0);
        chk({31'h0, irq}, 32'h0);
        axi_wr(12'h010, 32'h1);
        chk({31'h0, irq}, 32'h1);
        axi_wr(12'h014, 32'h1);
        chk({31'h0, irq}, 32'h0);
        axi_wr(12'h004, 32'h5a);
        axi_wr(12'h000, 32'h3a);
        axi_wr(12'h000, 32'h0);
        rchk(12'h000, 32'h3a);
        axi_wr(12'h000, 32'h04);
        rchk(12'h000, 32'h3e);
        axi_wr(12'h004, 32'ha5);
        rchk(12'h004, 32'h5a);
        chk({31'h0, lock}, 32'h1);
        reset_n_in <= 1'h0;
        repeat (6) @(posedge core_clk_in);
        reset_n_in <= 1'h1;
        rchk(12'h000, 32'h0);
        // open segment as RAM, then lock
        axi_wr(12'h000, 32'h04);
        hchk(32'h000b0000, 4'h8, 3'h0);
        axi_wr(12'h000, 32'h06);
        axi_wr(12'h000, 32'h0);
        rchk(12'h000, 32'h06);
        final_report;
    end
endmodule
